// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench
  import cmic_pkg::*;
;
  logic       sys_clk;
  logic       sys_rst;
  logic       cyc;
  logic       stb;
  logic       we;
  logic       sel;
  logic [7:0] adr;
  logic [7:0] wdat;
  logic [7:0] rdat;
  logic       ack;
  logic       err;
  logic       compOut;
  logic [1:0] respMode;
  logic [2:0] posSel;
  logic [2:0] negSel;
  logic       irq;
  int         badCount;
  int         cmpCount;
  int         cycles;
  logic [7:0] q;
  logic       e;

  cmic_top cmic_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .compOut(compOut), .responseMode(respMode),
    .posInputSel(posSel), .negInputSel(negSel), .compIrq(irq));

  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic printVerdict();
    $display("checks %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // hang guard, well above the hundred or so cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      printVerdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // one classic cycle; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] rq, output logic re);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1 && err !== 1'b1) @(posedge sys_clk);
    rq = rdat;
    re = err;
    cyc <= 0;
    stb <= 0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string m);
    bus(0, a, 8'h00, q, e);
    chk(q, x, m);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1, a, d, q, e);
  endtask

  initial begin
    {cyc, stb, we, compOut} = 4'h0;
    sel = 1;
    adr = 8'h00;
    wdat = 8'h00;
    sys_rst = 1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    rd(CMIC_MODE_OFS, 8'h02, "mode reset");
    chk({5'h00, respMode, irq}, 8'h04, "reset outputs");
    wr(CMIC_MODE_OFS, 8'hff);
    rd(CMIC_MODE_OFS, 8'h33, "top bits");
    for (int m = 0; m < 4; m++) begin
      wr(CMIC_MODE_OFS, 8'(m));
      chk({6'h00, respMode}, 8'(m), "response mode");
    end
    // pass 0 enables rise only, pass 1 fall only
    for (int i = 0; i < 2; i++) begin
      wr(CMIC_MODE_OFS, i ? 8'h10 : 8'h20);
      compOut <= 1;
      repeat (8) @(posedge sys_clk);
      chk({7'h00, irq}, 8'(i == 0), "rise request");
      rd(CMIC_FLAG_OFS, 8'h02, "rise flag");
      wr(CMIC_FLAG_OFS, 8'h03);
      compOut <= 0;
      repeat (8) @(posedge sys_clk);
      chk({7'h00, irq}, 8'(i == 1), "fall request");
      rd(CMIC_FLAG_OFS, 8'h01, "fall flag");
      wr(CMIC_FLAG_OFS, 8'h03);
      chk({7'h00, irq}, 8'h00, "request after clear");
    end
    bus(0, 8'h55, 8'h00, q, e);
    chk({7'h00, e}, 8'h01, "unmapped error");
    sys_rst <= 1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    rd(CMIC_MODE_OFS, 8'h02, "mode after reset");
    wr(CMIC_MUX_OFS, 8'hff);
    sel <= 0;
    wr(CMIC_MUX_OFS, 8'h00);
    sel <= 1;
    rd(CMIC_MUX_OFS, 8'h77, "mux readback");
    chk({1'b0, negSel, 1'b0, posSel}, 8'h77, "mux outputs");
    printVerdict();
  end
endmodule

// file: design/cmic_edge_detect.sv
`timescale 1ns/1ps
module cmic_edge_detect
  import cmic_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // asynchronous comparator level
  input  wire logic compOut,
  // detected edges, one-cycle pulses
  output logic      risePulse,
  output logic      fallPulse
);
  logic [2:0] syncReg;
  logic [2:0] syncNext;

  always_comb begin
    syncNext = {syncReg[1:0], compOut};
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      syncReg <= 3'h0;
    end else begin
      syncReg <= syncNext;
    end
  end

  // stage 0 feeds only stage 1; edges compare the settled stages
  assign risePulse = syncReg[1] & ~syncReg[2];
  assign fallPulse = ~syncReg[1] & syncReg[2];
endmodule

// file: design/cmic_pkg.sv
package cmic_pkg;
  localparam logic [7:0] CMIC_MODE_OFS    = 8'h9c;
  localparam logic [7:0] CMIC_MUX_OFS     = 8'h9e;
  localparam logic [7:0] CMIC_FLAG_OFS    = 8'ha0;
  localparam logic [7:0] CMIC_MODE_RESET  = 8'h02;
  localparam logic [7:0] CMIC_MODE_WMASK  = 8'h33;
  localparam logic [7:0] CMIC_MUX_RESET   = 8'h00;
  localparam logic [7:0] CMIC_MUX_WMASK   = 8'h77;
  localparam int         CMIC_RISE_BIT    = 5;
  localparam int         CMIC_FALL_BIT    = 4;
  localparam int         CMIC_FLAG_RISE   = 1;
  localparam int         CMIC_FLAG_FALL   = 0;

  typedef struct packed {
    logic [1:0] unused;
    logic       riseIrqEnable;
    logic       fallIrqEnable;
    logic [1:0] unusedMid;
    logic [1:0] responseMode;
  } cmic_mode_t;

  typedef struct packed {
    logic       riseFlag;
    logic       fallFlag;
  } cmic_flags_t;
endpackage

// file: design/cmic_top.sv
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module cmic_top
  import cmic_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // wishbone slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [7:0] wb_dat_i,
  input  wire logic       wb_sel_i,
  output logic [7:0]      wb_dat_o,
  output logic            wb_ack_o,
  output logic            wb_err_o,
  // analog comparator side
  input  wire logic       compOut,
  output logic [1:0]      responseMode,
  output logic [2:0]      posInputSel,
  output logic [2:0]      negInputSel,
  // interrupt request
  output logic            compIrq
);
  cmic_mode_t  modeReg;
  cmic_mode_t  modeNext;
  logic [7:0]  muxReg;
  logic [7:0]  muxNext;
  cmic_flags_t flagReg;
  cmic_flags_t flagNext;
  logic        ackReg;
  logic        ackNext;
  logic        errReg;
  logic        errNext;
  logic [7:0]  datReg;
  logic [7:0]  datNext;
  logic        irqReg;
  logic        irqNext;
  logic        risePulse;
  logic        fallPulse;
  logic        req;
  logic        wrEn;

  cmic_edge_detect cmic_edge_detect_inst (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .compOut   (compOut),
    .risePulse (risePulse),
    .fallPulse (fallPulse)
  );

  // ack drops the cycle after it is given; a held request is masked while ack or err is high, then seen again
  assign req  = wb_cyc_i & wb_stb_i & ~ackReg & ~errReg;
  assign wrEn = req & wb_we_i & wb_sel_i;

  always_comb begin
    modeNext = modeReg;
    muxNext  = muxReg;
    flagNext = flagReg;
    ackNext  = 1'b0;
    errNext  = 1'b0;
    datNext  = datReg;
    if (req) begin
      case (wb_adr_i)
        CMIC_MODE_OFS: begin
          ackNext = 1'b1;
          datNext = modeReg & CMIC_MODE_WMASK;
          if (wrEn) begin
            modeNext = wb_dat_i & CMIC_MODE_WMASK;
          end
        end
        CMIC_MUX_OFS: begin
          ackNext = 1'b1;
          datNext = muxReg;
          if (wrEn) begin
            muxNext = wb_dat_i & CMIC_MUX_WMASK;
          end
        end
        CMIC_FLAG_OFS: begin
          ackNext = 1'b1;
          datNext = {6'h00, flagReg};
          // write one to clear
          if (wrEn) begin
            flagNext.riseFlag = flagReg.riseFlag & ~wb_dat_i[CMIC_FLAG_RISE];
            flagNext.fallFlag = flagReg.fallFlag & ~wb_dat_i[CMIC_FLAG_FALL];
          end
        end
        default: begin
          errNext = 1'b1;
          datNext = 8'h00;
        end
      endcase
    end
    // a new edge beats a clear in the same cycle
    if (risePulse) begin
      flagNext.riseFlag = 1'b1;
    end
    if (fallPulse) begin
      flagNext.fallFlag = 1'b1;
    end
    irqNext = (flagReg.riseFlag & modeReg.riseIrqEnable) |
              (flagReg.fallFlag & modeReg.fallIrqEnable);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      modeReg <= cmic_mode_t'(CMIC_MODE_RESET);
      muxReg  <= CMIC_MUX_RESET;
      flagReg <= '0;
      ackReg  <= 1'b0;
      errReg  <= 1'b0;
      datReg  <= 8'h00;
      irqReg  <= 1'b0;
    end else begin
      modeReg <= modeNext;
      muxReg  <= muxNext;
      flagReg <= flagNext;
      ackReg  <= ackNext;
      errReg  <= errNext;
      datReg  <= datNext;
      irqReg  <= irqNext;
    end
  end

  assign wb_ack_o     = ackReg;
  assign wb_err_o     = errReg;
  assign wb_dat_o     = datReg;
  assign compIrq      = irqReg;
  assign responseMode = modeReg.responseMode;
  assign posInputSel  = muxReg[2:0];
  assign negInputSel  = muxReg[6:4];

  property p_mode_unused_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      modeReg.unused == 2'h0 && modeReg.unusedMid == 2'h0;
  endproperty
  a_mode_unused_zero: assert property (p_mode_unused_zero)
    else $error("mode register unused bits nonzero");

  property p_mode_read_top_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      (req && !wb_we_i && wb_adr_i == CMIC_MODE_OFS) |=> wb_ack_o && wb_dat_o[7:6] == 2'h0;
  endproperty
  a_mode_read_top_zero: assert property (p_mode_read_top_zero)
    else $error("mode read shows top bits set");

  property p_rise_enable_write;
    @(posedge sys_clk) disable iff (sys_rst)
      (wrEn && wb_adr_i == CMIC_MODE_OFS) |=>
        modeReg.riseIrqEnable == $past(wb_dat_i[CMIC_RISE_BIT]);
  endproperty
  a_rise_enable_write: assert property (p_rise_enable_write)
    else $error("rise enable not stored");

  property p_fall_enable_write;
    @(posedge sys_clk) disable iff (sys_rst)
      (wrEn && wb_adr_i == CMIC_MODE_OFS) |=>
        modeReg.fallIrqEnable == $past(wb_dat_i[CMIC_FALL_BIT]);
  endproperty
  a_fall_enable_write: assert property (p_fall_enable_write)
    else $error("fall enable not stored");

  property p_mode_write;
    @(posedge sys_clk) disable iff (sys_rst)
      (wrEn && wb_adr_i == CMIC_MODE_OFS) |=> responseMode == $past(wb_dat_i[1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("response mode not applied");

  property p_reset_value;
    @(posedge sys_clk) sys_rst |=> modeReg == cmic_mode_t'(CMIC_MODE_RESET) && !compIrq;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("mode register reset value wrong");

  sequence s_rise_armed;
    flagReg.riseFlag && modeReg.riseIrqEnable;
  endsequence
  property p_irq_follows;
    @(posedge sys_clk) disable iff (sys_rst)
      s_rise_armed |=> compIrq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("irq missing while rise flag enabled");

  property p_irq_cause;
    @(posedge sys_clk) disable iff (sys_rst)
      compIrq |-> $past(flagReg.riseFlag && modeReg.riseIrqEnable)
              || $past(flagReg.fallFlag && modeReg.fallIrqEnable);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq without enabled flag");

  sequence s_fall_armed;
    flagReg.fallFlag && modeReg.fallIrqEnable;
  endsequence
  property p_fall_irq_follows;
    @(posedge sys_clk) disable iff (sys_rst)
      s_fall_armed |=> compIrq;
  endproperty
  a_fall_irq_follows: assert property (p_fall_irq_follows)
    else $error("irq missing while fall flag enabled");

  // both enables low keep the request quiet whatever the flags hold
  property p_irq_blocked;
    @(posedge sys_clk) disable iff (sys_rst)
      (!modeReg.riseIrqEnable && !modeReg.fallIrqEnable) |=> !compIrq;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked)
    else $error("irq raised with both enables off");

  property p_mode_write_masked;
    @(posedge sys_clk) disable iff (sys_rst)
      (wrEn && wb_adr_i == CMIC_MODE_OFS) |=>
        modeReg == ($past(wb_dat_i) & CMIC_MODE_WMASK);
  endproperty
  a_mode_write_masked: assert property (p_mode_write_masked)
    else $error("mode write stored an unused bit");

  // an edge is never lost, even to a clear in the same cycle
  property p_rise_flag_set;
    @(posedge sys_clk) disable iff (sys_rst)
      risePulse |=> flagReg.riseFlag;
  endproperty
  a_rise_flag_set: assert property (p_rise_flag_set)
    else $error("rise edge lost");

  property p_fall_flag_set;
    @(posedge sys_clk) disable iff (sys_rst)
      fallPulse |=> flagReg.fallFlag;
  endproperty
  a_fall_flag_set: assert property (p_fall_flag_set)
    else $error("fall edge lost");

  // a held strobe must not see a second answer right behind the first
  property p_answer_pulse;
    @(posedge sys_clk) disable iff (sys_rst)
      (wb_ack_o || wb_err_o) |=> !wb_ack_o && !wb_err_o;
  endproperty
  a_answer_pulse: assert property (p_answer_pulse)
    else $error("bus answer held longer than one cycle");
endmodule
